/* src/dsl_pkg.sv */
// shared constants and types for the dual-channel serial load control block
// assumes a single 40 MHz system clock; the link pins are sampled by it
package dsl_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam int SEL_BIT = 15;
  localparam int BUF_BIT = 14;
  localparam int MODE_HI_BIT = 13;
  localparam int MODE_LO_BIT = 12;
  localparam int DATA_MSB = 11;
  localparam int CHANNELS = 2;

  // ----------------------------------------------------------------
  // channel code: 12, 10 or 8 significant bits, left aligned
  // ----------------------------------------------------------------
  localparam int CODE_BITS = 12;
  localparam int RESOLUTION = 12;
  localparam logic [CODE_BITS-1:0] CODE_MASK =
    CODE_BITS'(12'hfff << (CODE_BITS - RESOLUTION));

  // ----------------------------------------------------------------
  // operating modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PD_1K = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_PD_OPEN = 2'h3;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic BUF_RST = 1'b0;
  localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // frame tracker states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FR_WAIT_HIGH,
    FR_ARMED,
    FR_SHIFT
  } dsl_frame_e;

endpackage

/* src/dsl_chan_if.sv */
// carrier between the serial front end and one channel's register bank
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface dsl_chan_if;
  logic wrStb;
  logic refBufIn;
  logic [1:0] modeIn;
  logic [dsl_pkg::CODE_BITS-1:0] dataIn;
  logic loadActive;
  logic [dsl_pkg::CODE_BITS-1:0] inputCode;
  logic [dsl_pkg::CODE_BITS-1:0] dacCode;
  logic refBuf;
  logic [1:0] mode;
  logic changed;
  logic ampOn;
  logic pull1k;
  logic pull100k;
  logic openOut;

  modport ctrl (
    output wrStb, refBufIn, modeIn, dataIn, loadActive,
    input inputCode, dacCode, refBuf, mode, changed,
    input ampOn, pull1k, pull100k, openOut
  );

  modport chan (
    input wrStb, refBufIn, modeIn, dataIn, loadActive,
    output inputCode, dacCode, refBuf, mode, changed,
    output ampOn, pull1k, pull100k, openOut
  );
endinterface

`default_nettype wire

/* src/dsl_channel.sv */
// one channel: input register, dac register, settings and output stage
// assumes wrStb is a one-cycle pulse and loadActive a synchronised level
`timescale 1ns/1ps
`default_nettype none

module dsl_channel (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset, active low
  dsl_chan_if.chan bus // strobes in, register contents out
);

  logic [1:0] modeNext;

  // ----------------------------------------------------------------
  // input register and settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.inputCode <= dsl_pkg::CODE_RST;
    end else if (bus.wrStb) begin
      bus.inputCode <= bus.dataIn & dsl_pkg::CODE_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.refBuf <= dsl_pkg::BUF_RST;
      bus.mode <= dsl_pkg::MODE_RST;
    end else if (bus.wrStb) begin
      bus.refBuf <= bus.refBufIn;
      bus.mode <= bus.modeIn;
    end
  end

  // ----------------------------------------------------------------
  // change flag and dac register
  // ----------------------------------------------------------------
  // a write in the same cycle as a load keeps the flag set, so the new
  // code is still carried over on the following cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.changed <= 1'b0;
    end else if (bus.wrStb) begin
      bus.changed <= 1'b1;
    end else if (bus.loadActive && bus.changed) begin
      bus.changed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.dacCode <= dsl_pkg::CODE_RST;
    end else if (bus.loadActive && bus.changed && !bus.wrStb) begin
      bus.dacCode <= bus.inputCode;
    end
  end

  // ----------------------------------------------------------------
  // output stage; codes are never touched by power-down
  // ----------------------------------------------------------------
  always_comb begin
    modeNext = bus.wrStb ? bus.modeIn : bus.mode;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.ampOn <= 1'b1;
      bus.pull1k <= 1'b0;
      bus.pull100k <= 1'b0;
      bus.openOut <= 1'b0;
    end else begin
      bus.ampOn <= (modeNext == dsl_pkg::MODE_NORMAL);
      bus.pull1k <= (modeNext == dsl_pkg::MODE_PD_1K);
      bus.pull100k <= (modeNext == dsl_pkg::MODE_PD_100K);
      bus.openOut <= (modeNext == dsl_pkg::MODE_PD_OPEN);
    end
  end

endmodule

`default_nettype wire

/* src/dsl_serial_load_top.sv */
// serial front end and load control of a dual-channel dac
// assumes frame sync, serial clock, data and load strobe are asynchronous
// pins, sampled by a 40 MHz clock; the serial clock must stay well below
// a quarter of that rate for its edges to be seen
//
// What this block does
// - Power-up: normal mode, unbuffered reference, outputs at zero.
// - Reset clears input and dac registers until first valid write.
// - Frames enter a 16-bit shift register, four control bits, MSB first.
// - Bit 15 picks the channel: zero is A, one is B.
// - Bit 14 sets the addressed channel reference buffered; default zero.
// - Bits 13 and 12 pick normal or one of three power-down modes.
// - Mode and buffer bits touch only the addressed channel.
// - Low twelve bits are data; narrow variants ignore their low bits.
// - Channel data is straight binary, zero up to full scale.
// - Frame sync low is a chip enable; bits taken only then.
// - After sync falls, one bit per falling serial clock, 16 times.
// - Edges after sixteen ignored until sync rises and falls again.
// - A complete word is copied into the selected input register.
// - Sync rising before sixteen edges aborts; nothing is changed.
// - Receivers shut off after a full word until next sync fall.
// - Load strobe high holds dac registers; low passes input through.
// - A dac register reloads only if its input was written since.
// - Power-down disconnects amplifier, selects termination, stops analog.
// - Power-down leaves registers intact; normal mode resumes stored code.
`timescale 1ns/1ps
`default_nettype none

module dsl_serial_load_top (
  input wire logic clk, // 40 MHz system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic frameSyncN, // frame sync pin, active low
  input wire logic serialClk, // serial clock pin
  input wire logic serialData, // serial data pin
  input wire logic loadStrobeN, // load strobe pin, active low
  output logic [1:0][11:0] dacCode, // dac register per channel
  output logic [1:0][11:0] inputCode, // input register per channel
  output logic [1:0] refBuffered, // reference buffer enable per channel
  output logic [1:0] powerdownModeHi, // mode bit high per channel
  output logic [1:0] powerdownModeLo, // mode bit low per channel
  output logic [1:0] ampEnable, // output amplifier and analog on
  output logic [1:0] pullDown1k, // 1k termination to ground
  output logic [1:0] pullDown100k, // 100k termination to ground
  output logic [1:0] outputOpen, // output left high impedance
  output logic [1:0] changedFlag, // input written since last dac load
  output logic rxEnable, // serial receivers powered
  output logic wordDone, // pulse: full word taken
  output logic frameAbort, // pulse: frame cut short by sync
  output logic excessEdge, // pulse: serial edge after the sixteenth
  output logic [15:0] lastWord // last complete word received
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // stage one of each chain is read only by stage two
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic sclkPrev;
  logic syncPrev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= 4'hf;
      pinSync <= 4'hf;
    end else begin
      pinMeta <= {loadStrobeN, serialData, serialClk, frameSyncN};
      pinSync <= pinMeta;
    end
  end

  logic syncLow;
  logic sclkNow;
  logic dataNow;
  logic loadLow;

  always_comb begin
    syncLow = !pinSync[0];
    sclkNow = pinSync[1];
    dataNow = pinSync[2];
    loadLow = !pinSync[3];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev <= 1'b1;
      syncPrev <= 1'b1;
    end else begin
      sclkPrev <= sclkNow;
      syncPrev <= !syncLow;
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic sclkFall;
  logic syncFall;
  logic syncRise;

  always_comb begin
    sclkFall = sclkPrev && !sclkNow;
    syncFall = syncPrev && syncLow;
    syncRise = !syncPrev && !syncLow;
  end

  // ----------------------------------------------------------------
  // frame tracker
  // ----------------------------------------------------------------
  // after reset the tracker waits for sync high, but the synchronisers reset high, so a sync
  // that is already low when reset lifts is seen as a fall and starts a frame midway
  dsl_pkg::dsl_frame_e frame_reg;
  dsl_pkg::dsl_frame_e frame_next;
  logic [4:0] bitCount_reg;
  logic [4:0] bitCount_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic takeBit;
  logic complete;
  logic abort;
  logic extra;

  always_comb begin
    frame_next = frame_reg;
    bitCount_next = bitCount_reg;
    shift_next = shift_reg;
    takeBit = 1'b0;
    complete = 1'b0;
    abort = 1'b0;
    extra = 1'b0;
    case (frame_reg)
      dsl_pkg::FR_WAIT_HIGH: begin
        // receivers off until sync has gone high
        if (!syncLow) begin
          frame_next = dsl_pkg::FR_ARMED;
        end else if (sclkFall) begin
          extra = 1'b1;
        end
      end
      dsl_pkg::FR_ARMED: begin
        // armed is only entered with sync high, so its first low is a fall
        if (syncFall) begin
          frame_next = dsl_pkg::FR_SHIFT;
          bitCount_next = 5'h00;
          takeBit = sclkFall;
        end
      end
      dsl_pkg::FR_SHIFT: begin
        if (syncRise) begin
          // early rise drops the partial word
          abort = 1'b1;
          frame_next = dsl_pkg::FR_ARMED;
        end else begin
          takeBit = sclkFall;
        end
      end
      default: begin
        frame_next = dsl_pkg::FR_WAIT_HIGH;
      end
    endcase
    if (takeBit) begin
      shift_next = {shift_reg[14:0], dataNow};
      bitCount_next = 5'(bitCount_next + 5'h01);
      if (bitCount_next == dsl_pkg::FRAME_LEN) begin
        complete = 1'b1;
        frame_next = dsl_pkg::FR_WAIT_HIGH;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_reg <= dsl_pkg::FR_WAIT_HIGH;
    end else begin
      frame_reg <= frame_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCount_reg <= 5'h00;
      shift_reg <= dsl_pkg::WORD_RST;
    end else begin
      bitCount_reg <= bitCount_next;
      shift_reg <= shift_next;
    end
  end

  // ----------------------------------------------------------------
  // status pulses and receiver power
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wordDone <= 1'b0;
      frameAbort <= 1'b0;
      excessEdge <= 1'b0;
    end else begin
      wordDone <= complete;
      frameAbort <= abort;
      excessEdge <= extra;
    end
  end

  // clock and data receivers wake only on a sync fall; the sync pin
  // itself is always watched, so nothing is lost while they sleep
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxEnable <= 1'b0;
    end else begin
      rxEnable <= (frame_next == dsl_pkg::FR_SHIFT);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastWord <= dsl_pkg::WORD_RST;
    end else if (complete) begin
      lastWord <= shift_next;
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  logic chanSel;
  logic bufSel;
  logic [1:0] modeSel;
  logic [11:0] codeSel;

  always_comb begin
    chanSel = shift_next[dsl_pkg::SEL_BIT];
    bufSel = shift_next[dsl_pkg::BUF_BIT];
    modeSel = {shift_next[dsl_pkg::MODE_HI_BIT],
               shift_next[dsl_pkg::MODE_LO_BIT]};
    codeSel = shift_next[dsl_pkg::DATA_MSB:0];
  end

  // ----------------------------------------------------------------
  // channel banks
  // ----------------------------------------------------------------
  // the load strobe acts as a level: while low each bank keeps moving
  // fresh input codes through, so a write during a held-low strobe
  // reaches the dac a cycle later
  genvar ch;
  generate
    for (ch = 0; ch < dsl_pkg::CHANNELS; ch++) begin : g_chan
      dsl_chan_if cbus ();

      always_comb begin
        cbus.wrStb = complete && (chanSel == 1'(ch));
        cbus.refBufIn = bufSel;
        cbus.modeIn = modeSel;
        cbus.dataIn = codeSel;
        cbus.loadActive = loadLow;
      end

      dsl_channel u_chan (
        .clk(clk),
        .nrst(nrst),
        .bus(cbus.chan)
      );

      always_comb begin
        dacCode[ch] = cbus.dacCode;
        inputCode[ch] = cbus.inputCode;
        refBuffered[ch] = cbus.refBuf;
        powerdownModeHi[ch] = cbus.mode[1];
        powerdownModeLo[ch] = cbus.mode[0];
        ampEnable[ch] = cbus.ampOn;
        pullDown1k[ch] = cbus.pull1k;
        pullDown100k[ch] = cbus.pull100k;
        outputOpen[ch] = cbus.openOut;
        changedFlag[ch] = cbus.changed;
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* testbench/dsl_serial_load_chk.sv */
// port assertions for the dual-channel serial load block
// assumes binding to dsl_serial_load_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dsl_serial_load_chk (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic loadStrobeN, // load pin
  input wire logic [1:0][11:0] dacCode, // dac registers
  input wire logic [1:0][11:0] inputCode, // input registers
  input wire logic [1:0] refBuffered, // buffer bits
  input wire logic [1:0] powerdownModeHi, // mode high bits
  input wire logic [1:0] powerdownModeLo, // mode low bits
  input wire logic [1:0] ampEnable, // amplifier on
  input wire logic [1:0] pullDown1k, // 1k load
  input wire logic [1:0] pullDown100k, // 100k load
  input wire logic [1:0] outputOpen, // open output
  input wire logic [1:0] changedFlag, // written since load
  input wire logic rxEnable, // receivers on
  input wire logic wordDone, // word pulse
  input wire logic frameAbort, // abort pulse
  input wire logic excessEdge, // extra edge pulse
  input wire logic [15:0] lastWord // last word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_word_input: assert property (
    wordDone |-> inputCode[lastWord[15]] == lastWord[11:0])
    else $error("input register differs from word");
  a_word_settings: assert property (
    wordDone |-> refBuffered[lastWord[15]] == lastWord[14]
      && powerdownModeHi[lastWord[15]] == lastWord[13]
      && powerdownModeLo[lastWord[15]] == lastWord[12])
    else $error("settings differ from word");
  a_other_kept: assert property (
    wordDone |-> (lastWord[15]
      ? $stable(inputCode[0]) && $stable(refBuffered[0])
      : $stable(inputCode[1]) && $stable(refBuffered[1])))
    else $error("other channel changed");
  a_word_flag: assert property (
    wordDone |-> changedFlag[lastWord[15]])
    else $error("change flag not set");
  a_rx_off: assert property (
    wordDone |=> !rxEnable)
    else $error("receivers stay on after word");
  a_abort_keeps: assert property (
    frameAbort |-> $stable(inputCode) && $stable(refBuffered)
      && $stable(powerdownModeHi) && $stable(powerdownModeLo))
    else $error("aborted frame changed state");
  a_dac_hold: assert property (
    !$stable(dacCode) |-> !$past(loadStrobeN, 2) || !$past(loadStrobeN, 3)
      || !$past(loadStrobeN, 4))
    else $error("dac changed with load high");
  a_dac_copy_a: assert property (
    !$stable(dacCode[0]) |-> dacCode[0] == $past(inputCode[0])
      && $past(changedFlag[0]))
    else $error("channel a dac load wrong");
  a_dac_copy_b: assert property (
    !$stable(dacCode[1]) |-> dacCode[1] == $past(inputCode[1])
      && $past(changedFlag[1]))
    else $error("channel b dac load wrong");
  a_term_map: assert property (
    ampEnable == ~(powerdownModeHi | powerdownModeLo)
      && pullDown1k == (~powerdownModeHi & powerdownModeLo)
      && pullDown100k == (powerdownModeHi & ~powerdownModeLo)
      && outputOpen == (powerdownModeHi & powerdownModeLo))
    else $error("termination does not match mode");
  a_excess_idle: assert property (
    excessEdge |-> $stable(inputCode) && !wordDone)
    else $error("extra edge was taken");
endmodule
bind dsl_serial_load_top dsl_serial_load_chk i_chk (.clk(clk), .nrst(nrst),
  .loadStrobeN(loadStrobeN), .dacCode(dacCode), .inputCode(inputCode),
  .refBuffered(refBuffered), .powerdownModeHi(powerdownModeHi),
  .powerdownModeLo(powerdownModeLo), .ampEnable(ampEnable),
  .pullDown1k(pullDown1k), .pullDown100k(pullDown100k),
  .outputOpen(outputOpen), .changedFlag(changedFlag), .rxEnable(rxEnable),
  .wordDone(wordDone), .frameAbort(frameAbort), .excessEdge(excessEdge),
  .lastWord(lastWord));
`default_nettype wire

/* testbench/dsl_host_model.sv */
// host serial port model driving frame sync, serial clock and data
// assumes the bench clock paces it; changes land on its falling edge
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
  input wire logic clk, // bench clock
  output logic frameSyncN, // frame sync, idle high
  output logic serialClk, // stands high between frames
  output logic serialData // link data
);
  localparam int HALF = 4; // 100 ns half period
  initial begin
    frameSyncN = 1'b1;
    serialClk = 1'b1;
    serialData = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // n below 16 cuts the frame short, above 16 adds edges to be ignored
  task automatic send(input logic [15:0] w, input int n);
    frameSyncN = 1'b0;
    idle(HALF);
    for (int i = 0; i < n; i++) begin
      serialData = (i < 16) ? w[15 - i] : ~w[i % 16];
      idle(HALF);
      serialClk = 1'b0;
      idle(HALF);
      serialClk = 1'b1;
    end
    frameSyncN = 1'b1;
    serialData = ~serialData; // released line must not show a stale bit
    idle(3 * HALF);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the dual-channel serial load block
// assumes the host model and checker files are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("unexpected %s: expected %h, seen %h", name, \
  exp, got); end end
module tb_top;
  logic clk, nrst, loadStrobeN;
  wire frameSyncN, serialClk, serialData;
  logic [1:0][11:0] dacCode, inputCode;
  logic [1:0] refBuffered, powerdownModeHi, powerdownModeLo, ampEnable;
  logic [1:0] pullDown1k, pullDown100k, outputOpen, changedFlag;
  logic rxEnable, wordDone, frameAbort, excessEdge;
  logic [15:0] lastWord;
  logic sawAbort = 1'b0;
  logic sawExcess = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  dsl_host_model i_host (.clk(clk), .frameSyncN(frameSyncN),
    .serialClk(serialClk), .serialData(serialData));
  dsl_serial_load_top i_dut (.clk(clk), .nrst(nrst), .frameSyncN(frameSyncN),
    .serialClk(serialClk), .serialData(serialData), .loadStrobeN(loadStrobeN),
    .dacCode(dacCode), .inputCode(inputCode), .refBuffered(refBuffered),
    .powerdownModeHi(powerdownModeHi), .powerdownModeLo(powerdownModeLo),
    .ampEnable(ampEnable), .pullDown1k(pullDown1k),
    .pullDown100k(pullDown100k), .outputOpen(outputOpen),
    .changedFlag(changedFlag), .rxEnable(rxEnable), .wordDone(wordDone),
    .frameAbort(frameAbort), .excessEdge(excessEdge), .lastWord(lastWord));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (frameAbort === 1'b1) sawAbort <= 1'b1;
    if (excessEdge === 1'b1) sawExcess <= 1'b1;
  end
  task automatic load();
    loadStrobeN = 1'b0;
    repeat (4) @(negedge clk);
    loadStrobeN = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    loadStrobeN = 1'b1;
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("inputCode", 24'h00_0000, inputCode)
    `CHK("dacCode", 24'h00_0000, dacCode)
    `CHK("refBuffered", 2'h0, refBuffered)
    `CHK("ampEnable", 2'h3, ampEnable)
    $display("test reset state done");
    i_host.send(16'h4abc, 16);
    `CHK("inputCode", {12'h000, 12'habc}, inputCode)
    `CHK("refBuffered", 2'h1, refBuffered)
    `CHK("dacCode", 24'h00_0000, dacCode)
    `CHK("changedFlag", 2'h1, changedFlag)
    i_host.send(16'h9fff, 16);
    `CHK("inputCode", {12'hfff, 12'habc}, inputCode)
    `CHK("pullDown1k", 2'h2, pullDown1k)
    `CHK("refBuffered", 2'h1, refBuffered)
    `CHK("lastWord", 16'h9fff, lastWord)
    `CHK("rxEnable", 1'b0, rxEnable)
    load();
    `CHK("dacCode", {12'hfff, 12'habc}, dacCode)
    `CHK("changedFlag", 2'h0, changedFlag)
    $display("test write and load done");
    loadStrobeN = 1'b0;
    i_host.send(16'h0555, 16);
    `CHK("dacCode", {12'hfff, 12'h555}, dacCode)
    loadStrobeN = 1'b1;
    i_host.send(16'hc000, 10);
    `CHK("inputCode", {12'hfff, 12'h555}, inputCode)
    `CHK("mode", 4'h2, {powerdownModeHi, powerdownModeLo})
    `CHK("sawAbort", 1'b1, sawAbort)
    i_host.send(16'h8123, 20);
    `CHK("inputCode", {12'h123, 12'h555}, inputCode)
    `CHK("sawExcess", 1'b1, sawExcess)
    `CHK("lastWord", 16'h8123, lastWord)
    $display("test abort and extra edges done");
    load();
    for (int m = 0; m < 4; m++) begin
      i_host.send({2'b10, 2'(m), 12'h321}, 16);
      `CHK("modeB", 2'(m),
        {powerdownModeHi[1], powerdownModeLo[1]})
      `CHK("termB", 4'h1 << m, {outputOpen[1], pullDown100k[1], pullDown1k[1],
        ampEnable[1]})
      load();
      `CHK("dacCode", {12'h321, 12'h555}, dacCode)
    end
    i_host.send(16'h8777, 16);
    `CHK("inputCode", {12'h777, 12'h555}, inputCode)
    `CHK("dacCode", {12'h321, 12'h555}, dacCode)
    `CHK("ampEnable", 2'h3, ampEnable)
    $display("test power-down modes done");
    results();
  end
endmodule
`default_nettype wire
